// File: gpdpw_top.sv
// gpio direction, pull, wake and external interrupt configuration with wishbone slave
`timescale 1ns/1ns
`include "gpdpw_regs.svh"

module gpdpw_top
  import gpdpw_pkg::*;
#(
  parameter int FILT_CYC = `GPDPW_FILT_CYC  // filter settle cycles
) (
  input  wire logic          clk_i,       // 100 MHz clock
  input  wire logic          rst_i,       // sync reset, high
  input  wire gpdpw_wb_req_t wb_i,        // wishbone request
  output logic [31:0]        wb_dat_o,    // read data
  output logic               wb_ack_o,    // acknowledge
  input  wire logic [16:0]   pin_i,       // pin levels
  input  wire logic [3:0]    ext_int_i,   // channel sources a..d
  output logic [16:0]        oe_o,        // output enables
  output logic [16:0]        pd_o,        // pull-down enables
  output logic [16:0]        pu_o,        // pull-up enables
  output logic [3:0]         chan_req_o,  // per-channel requests
  output logic               irq_o,       // any channel request
  output logic               wake_o       // wake event pending
);

  // refuse filter counts the counter cannot hold
  if (FILT_CYC < 1 || FILT_CYC > 255) begin : g_bad_filt
    $error("FILT_CYC must be 1 to 255");
  end

  localparam logic [7:0] FILT_LAST = 8'(FILT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]      oel_r, pdl_r, pul_r, wake_en_r, wstat_r;
  logic             oeh_r, pdh_r, puh_r;
  logic [3:0]       flag_r, ien_r;
  gpdpw_cfg_t       cfg_r [`GPDPW_NCH];
  logic             ack_r;
  logic [31:0]      dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; offsets are indices so low two address bits must be zero
  wire        req     = wb_i.cyc & wb_i.stb;
  wire        in_rng  = (wb_i.adr[31:18] == 14'h0000) && (wb_i.adr[1:0] == 2'b00);
  wire [15:0] idx     = wb_i.adr[17:2];
  // writes land on the edge where the master sees ack
  wire        wr      = req & wb_i.we & ack_r & in_rng;
  wire [15:0] wm      = {{8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
  wire [15:0] wd      = wb_i.dat[15:0] & wm;

  wire hit_flag   = idx == `GPDPW_IX_FLAG;
  wire hit_ien    = idx == `GPDPW_IX_IEN;
  wire hit_oeh    = idx == `GPDPW_IX_OEH;
  wire hit_oel    = idx == `GPDPW_IX_OEL;
  wire hit_oeseth = idx == `GPDPW_IX_OESETH;
  wire hit_oesetl = idx == `GPDPW_IX_OESETL;
  wire hit_oeclrh = idx == `GPDPW_IX_OECLRH;
  wire hit_oeclrl = idx == `GPDPW_IX_OECLRL;
  wire hit_pdh    = idx == `GPDPW_IX_PDH;
  wire hit_pdl    = idx == `GPDPW_IX_PDL;
  wire hit_puh    = idx == `GPDPW_IX_PUH;
  wire hit_pul    = idx == `GPDPW_IX_PUL;
  wire hit_wake   = idx == `GPDPW_IX_WAKEL;
  wire hit_wstat  = idx == `GPDPW_IX_WSTAT;
  wire [3:0] hit_cfg = {idx == `GPDPW_IX_CFGD, idx == `GPDPW_IX_CFGC,
                        idx == `GPDPW_IX_CFGB, idx == `GPDPW_IX_CFGA};

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, a change counts once stages 2 and 3 agree
  logic [20:0] s1_r, s2_r, s3_r, lvl_r;
  wire  [20:0] agree   = ~(s2_r ^ s3_r);
  wire  [20:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= 21'h000000;
      s2_r  <= 21'h000000;
      s3_r  <= 21'h000000;
      lvl_r <= 21'h000000;
    end else begin
      s1_r  <= {ext_int_i, pin_i};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  wire [16:0] pin_lvl = lvl_r[16:0];
  wire [3:0]  ext_lvl = lvl_r[20:17];

  ////////////////////////////////////////////////////////////////////////////
  // wake monitoring: a settled change on an enabled pin is a sticky event
  logic [15:0] pin_prev_r;
  wire  [15:0] wake_evt  = (pin_lvl[15:0] ^ pin_prev_r) & wake_en_r;
  wire  [15:0] wstat_clr = (wr & hit_wstat) ? wd : 16'h0000;
  // set wins over a clear in the same cycle
  wire  [15:0] wstat_nxt = (wstat_r & ~wstat_clr) | wake_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_r <= `GPDPW_RST16;
      wstat_r    <= `GPDPW_RST16;
    end else begin
      pin_prev_r <= pin_lvl[15:0];
      wstat_r    <= wstat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external channels: optional filter, then edge or level detection
  logic [3:0] trig;

  for (genvar c = 0; c < `GPDPW_NCH; c++) begin : g_ch
    logic [7:0] cnt_r;
    logic       filt_lvl_r, prev_r;
    // filter holds off a new level until it has stood FILT_CYC cycles
    wire        differ = ext_lvl[c] != filt_lvl_r;
    wire        settle = differ & (cnt_r == FILT_LAST);
    wire        src    = cfg_r[c].filt ? filt_lvl_r : ext_lvl[c];
    wire        rise   = src & ~prev_r;
    wire        fall   = ~src & prev_r;
    logic       hit;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_r      <= 8'h00;
        filt_lvl_r <= 1'b0;
        prev_r     <= 1'b0;
      end else begin
        cnt_r      <= (differ & ~settle) ? cnt_r + 8'h01 : 8'h00;
        filt_lvl_r <= (settle | ~cfg_r[c].filt) ? ext_lvl[c] : filt_lvl_r;
        prev_r     <= src;
      end
    end

    // codes 6 and 7 are reserved and simply never trigger
    always_comb begin
      unique case (cfg_r[c].mode)
        GPDPW_TM_OFF:  hit = 1'b0;
        GPDPW_TM_RISE: hit = rise;
        GPDPW_TM_FALL: hit = fall;
        GPDPW_TM_BOTH: hit = rise | fall;
        GPDPW_TM_HIGH: hit = src;
        GPDPW_TM_LOW:  hit = ~src;
        default:       hit = 1'b0;
      endcase
    end
    assign trig[c] = hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags: level modes keep setting while the level holds
  wire [3:0] flag_clr = (wr & hit_flag) ? wd[3:0] : 4'h0;
  wire [3:0] flag_nxt = (flag_r & ~flag_clr) | trig;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= `GPDPW_RST4;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output enables: in the set and clear registers only written ones act, zeros leave bits alone
  wire [15:0] oel_set = (wr & hit_oesetl) ? wd : 16'h0000;
  wire [15:0] oel_clr = (wr & hit_oeclrl) ? wd : 16'h0000;
  wire [15:0] oel_wr  = (wr & hit_oel) ? ((oel_r & ~wm) | wd) : oel_r;
  wire [15:0] oel_nxt = (oel_wr | oel_set) & ~oel_clr;
  wire        oeh_set = wr & hit_oeseth & wd[0];
  wire        oeh_clr = wr & hit_oeclrh & wd[0];
  wire        oeh_wr  = (wr & hit_oeh & wm[0]) ? wd[0] : oeh_r;
  wire        oeh_nxt = (oeh_wr | oeh_set) & ~oeh_clr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oel_r <= `GPDPW_RST16;
      oeh_r <= 1'b0;
    end else begin
      oel_r <= oel_nxt;
      oeh_r <= oeh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain read-write controls, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdl_r     <= `GPDPW_RST16;
      pul_r     <= `GPDPW_RST16;
      wake_en_r <= `GPDPW_RST16;
      pdh_r     <= 1'b0;
      puh_r     <= 1'b0;
      ien_r     <= `GPDPW_RST4;
    end else if (wr) begin
      if (hit_pdl)  pdl_r     <= (pdl_r & ~wm) | wd;
      if (hit_pul)  pul_r     <= (pul_r & ~wm) | wd;
      if (hit_wake) wake_en_r <= (wake_en_r & ~wm) | wd;
      if (hit_pdh & wm[0]) pdh_r <= wd[0];
      if (hit_puh & wm[0]) puh_r <= wd[0];
      if (hit_ien & wm[0]) ien_r <= wd[3:0];
    end
  end

  // channel configuration; mode sits in the low lane, filter in the high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `GPDPW_NCH; i++) begin
        cfg_r[i] <= '{filt: 1'b0, mode: GPDPW_TM_OFF};
      end
    end else begin
      for (int i = 0; i < `GPDPW_NCH; i++) begin
        if (wr & hit_cfg[i] & wm[`GPDPW_CFG_FILT]) begin
          cfg_r[i].filt <= wd[`GPDPW_CFG_FILT];
        end
        if (wr & hit_cfg[i] & wm[0]) begin
          cfg_r[i].mode <= gpdpw_trig_t'(wd[`GPDPW_CFG_MMSB:`GPDPW_CFG_MLSB]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; set/clear registers and unmapped words read zero
  function automatic logic [15:0] cfg_word(input gpdpw_cfg_t c);
    cfg_word = {7'h00, c.filt, c.mode, 5'h00};
  endfunction : cfg_word

  wire [15:0] rd_val =
      hit_flag   ? {12'h000, flag_r}    :
      hit_ien    ? {12'h000, ien_r}     :
      hit_cfg[0] ? cfg_word(cfg_r[0])   :
      hit_cfg[1] ? cfg_word(cfg_r[1])   :
      hit_cfg[2] ? cfg_word(cfg_r[2])   :
      hit_cfg[3] ? cfg_word(cfg_r[3])   :
      hit_oeh    ? {15'h0000, oeh_r}    :
      hit_oel    ? oel_r                :
      hit_pdh    ? {15'h0000, pdh_r}    :
      hit_pdl    ? pdl_r                :
      hit_puh    ? {15'h0000, puh_r}    :
      hit_pul    ? pul_r                :
      hit_wake   ? wake_en_r            :
      hit_wstat  ? wstat_r              : 16'h0000;

  // single wait state: ack one cycle after the request, dropped next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= in_rng ? {16'h0000, rd_val} : 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = dat_r;
  assign oe_o       = {oeh_r, oel_r};
  assign pd_o       = {pdh_r, pdl_r};
  assign pu_o       = {puh_r, pul_r};
  assign chan_req_o = flag_r & ien_r;
  assign irq_o      = |chan_req_o;
  assign wake_o     = |wstat_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  oe_set_low_a: assert property (wr & hit_oesetl |=> (oe_o[15:0] & $past(wd)) == $past(wd))
    else $error("set-low did not raise enables");
  oe_zero_keep_a: assert property (wr & (hit_oesetl | hit_oeclrl) |=>
      ((oe_o[15:0] ^ $past(oe_o[15:0])) & ~$past(wd)) == 16'h0000)
    else $error("zero bit changed an enable");
  oe_clr_high_a: assert property (wr & hit_oeclrh & wd[0] |=> !oe_o[16])
    else $error("clear-high left pin 16 enabled");
  oe_clr_low_a: assert property (wr & hit_oeclrl |=> (oe_o[15:0] & $past(wd)) == 16'h0000)
    else $error("clear-low left enables set");
  pd_high_a: assert property (wr & hit_pdh & wm[0] |=> pd_o[16] == $past(wd[0]))
    else $error("pull-down pin 16 wrong");
  pd_low_a: assert property (wr & hit_pdl & (wm == 16'hFFFF) |=> pd_o[15:0] == $past(wd))
    else $error("pull-down low wrong");
  pu_high_a: assert property (wr & hit_puh & wm[0] |=> pu_o[16] == $past(wd[0]))
    else $error("pull-up pin 16 wrong");
  pu_low_a: assert property (wr & hit_pul & (wm == 16'hFFFF) |=> pu_o[15:0] == $past(wd))
    else $error("pull-up low wrong");
  wake_evt_a: assert property (wake_evt != 16'h0000 |=> wake_o)
    else $error("wake event lost");
  rise_flag_a: assert property (cfg_r[1].mode == GPDPW_TM_RISE
      && $rose(g_ch[1].src) |=> flag_r[1])
    else $error("rising edge did not flag");
  level_flag_a: assert property (cfg_r[0].mode == GPDPW_TM_HIGH && !cfg_r[0].filt
      && ext_lvl[0] |=> flag_r[0])
    else $error("high level did not flag");
  off_quiet_a: assert property (cfg_r[2].mode == GPDPW_TM_OFF |-> !trig[2])
    else $error("disabled channel triggered");
  // a one-cycle settle legally passes at once, so only longer filters must hold
  filt_hold_a: assert property (FILT_CYC > 1 && cfg_r[3].filt && $changed(ext_lvl[3]) |=>
      $stable(g_ch[3].filt_lvl_r))
    else $error("filter passed a one-cycle change");
  flag_set_wins_a: assert property (trig[0] && wr && hit_flag && wd[0] |=> flag_r[0])
    else $error("clear beat a trigger");
  ien_read_a: assert property (req && !ack_r && hit_ien && in_rng |=> wb_dat_o[31:4] == 28'h0)
    else $error("enable upper bits not zero");
  setreg_zero_a: assert property (req && !ack_r && in_rng && (hit_oesetl || hit_oeclrl)
      |=> wb_dat_o == 32'h00000000)
    else $error("set/clear register read non-zero");
  req_and_a: assert property (irq_o |-> (flag_r & ien_r) != 4'h0 ##0 chan_req_o != 4'h0)
    else $error("request without flag and enable");
  ack_one_a: assert property (req && !ack_r |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  cov_set_clear_c: cover property (wr & hit_oesetl ##[1:20] wr & hit_oeclrl);
  cov_both_edge_c: cover property (cfg_r[0].mode == GPDPW_TM_BOTH && trig[0]);
  cov_irq_c:       cover property (irq_o);
  cov_wake_c:      cover property ($rose(wake_o));

endmodule : gpdpw_top

// File: gpdpw_regs.svh
// register indices, field positions, reset values and timing counts of the gpio config block
`ifndef GPDPW_REGS_SVH
`define GPDPW_REGS_SVH

// register indices; byte address is four times the index
`define GPDPW_IX_FLAG    16'h4610
`define GPDPW_IX_IEN     16'h4612
`define GPDPW_IX_CFGA    16'h4630
`define GPDPW_IX_CFGB    16'h4632
`define GPDPW_IX_CFGC    16'h4634
`define GPDPW_IX_CFGD    16'h4636
`define GPDPW_IX_OEH     16'h4714
`define GPDPW_IX_OEL     16'h4716
`define GPDPW_IX_OESETH  16'h4718
`define GPDPW_IX_OESETL  16'h471A
`define GPDPW_IX_OECLRH  16'h471C
`define GPDPW_IX_OECLRL  16'h471E
`define GPDPW_IX_PDH     16'h4720
`define GPDPW_IX_PDL     16'h4722
`define GPDPW_IX_PUH     16'h4724
`define GPDPW_IX_PUL     16'h4726
`define GPDPW_IX_WAKEL   16'h4728
`define GPDPW_IX_WSTAT   16'h472A

// field positions
`define GPDPW_CFG_FILT   8
`define GPDPW_CFG_MLSB   5
`define GPDPW_CFG_MMSB   7
`define GPDPW_NCH        4

// reset values
`define GPDPW_RST16      16'h0000
`define GPDPW_RST4       4'h0

// filter settle time, least time so rounded up
`define GPDPW_CLK_NS     10
`define GPDPW_FILT_NS    40
`define GPDPW_FILT_CYC   ((`GPDPW_FILT_NS + `GPDPW_CLK_NS - 1) / `GPDPW_CLK_NS)

`endif

// File: gpdpw_pkg.sv
// types shared by the gpio config block
package gpdpw_pkg;

  // channel trigger modes; 6 and 7 are not legal
  typedef enum logic [2:0] {
    GPDPW_TM_OFF  = 3'b000,
    GPDPW_TM_RISE = 3'b001,
    GPDPW_TM_FALL = 3'b010,
    GPDPW_TM_BOTH = 3'b011,
    GPDPW_TM_HIGH = 3'b100,
    GPDPW_TM_LOW  = 3'b101
  } gpdpw_trig_t;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } gpdpw_wb_req_t;

  // per-channel configuration
  typedef struct packed {
    logic        filt;
    gpdpw_trig_t mode;
  } gpdpw_cfg_t;

endpackage : gpdpw_pkg

// File: gpdpw_pin_model.sv
// external pins and interrupt sources facing the gpio config block
`timescale 1ns/1ns

module gpdpw_pin_model (
  input  wire logic [16:0] drv_en_i,   // model drives the pin
  input  wire logic        clk_i,      // system clock
  input  wire logic [16:0] drv_lvl_i,  // level where driven
  input  wire logic [16:0] pd_i,       // pull-down enables
  input  wire logic [16:0] pu_i,       // pull-up enables
  input  wire logic [3:0]  src_i,      // wanted source levels
  output logic      [16:0] pin_o,      // pin levels seen by block
  output logic      [3:0]  ext_o       // channel sources
);
  logic [16:0] float_r = 17'h0AAAA;  // floating pins never hold a steady value

  ////////////////////////////////////////////////////////////////////////////
  // sources change only just after an edge, like a real board
  always @(posedge clk_i) begin
    float_r <= ~float_r;
    ext_o   <= src_i;
  end

  // a pull only wins where nobody drives the pin
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      if (drv_en_i[i]) begin
        pin_o[i] = drv_lvl_i[i];
      end else if (pu_i[i]) begin
        pin_o[i] = 1'h1;
      end else if (pd_i[i]) begin
        pin_o[i] = 1'h0;
      end else begin
        pin_o[i] = float_r[i];
      end
    end
  end
endmodule : gpdpw_pin_model

// File: testbench.sv
// self-checking bench for the gpio config block
`timescale 1ns/1ns
`include "gpdpw_regs.svh"

module testbench;
  import gpdpw_pkg::*;
  logic          clk_i, rst_i, wb_ack_o, irq_o, wake_o, idle, hit, lvl;
  gpdpw_wb_req_t req;
  logic [31:0]   wb_dat_o, seed;
  logic [16:0]   pin_i, oe_o, pd_o, pu_o, drv_en, drv_lvl;
  logic [3:0]    ext_int_i, chan_req_o, src;
  logic [15:0]   exp_q[$];
  logic [15:0]   a, b, cfgw, bitv;
  logic [15:0]   pv[4];
  logic [15:0]   pull_ix[4] = '{`GPDPW_IX_PDL, `GPDPW_IX_PDH, `GPDPW_IX_PUL, `GPDPW_IX_PUH};
  logic [15:0]   pull_mk[4] = '{16'hFFFF, 16'h0001, 16'hFFFF, 16'h0001};
  logic [15:0]   cfg_ix[4] = '{`GPDPW_IX_CFGA, `GPDPW_IX_CFGB, `GPDPW_IX_CFGC, `GPDPW_IX_CFGD};
  logic [15:0]   rst_ix[9] = '{`GPDPW_IX_OEL, `GPDPW_IX_OEH, `GPDPW_IX_PDL, `GPDPW_IX_PUH, `GPDPW_IX_WAKEL,
                               `GPDPW_IX_CFGA, `GPDPW_IX_CFGD, `GPDPW_IX_IEN, `GPDPW_IX_FLAG};
  int            failures, checks, ch;

  gpdpw_top #(.FILT_CYC(2)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_i(pin_i), .ext_int_i(ext_int_i), .oe_o(oe_o), .pd_o(pd_o), .pu_o(pu_o),
    .chan_req_o(chan_req_o), .irq_o(irq_o), .wake_o(wake_o));
  gpdpw_pin_model i_pins (.drv_en_i(drv_en), .clk_i(clk_i), .drv_lvl_i(drv_lvl), .pd_i(pd_o), .pu_i(pu_o),
    .src_i(src), .pin_o(pin_i), .ext_o(ext_int_i));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic rnd(output logic [15:0] v);
    seed = xs(seed);
    v = seed[15:0];
  endtask : rnd

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic timeout;
    failures++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'h0, 1'h1);
    tally_and_finish();
  endtask : timeout

  // one classic cycle; ack sampled at the rising edge, request held until then
  task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d, input logic [15:0] e);
    int n;
    n = 0;
    @(posedge clk_i);
    if (!we) exp_q.push_back(e);
    req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {14'h0000, idx, 2'h0}, sel: 4'h3, dat: {16'h0000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (wb_ack_o !== 1'h1) timeout();
    req <= '0;
  endtask : wb

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    wb(1'h1, idx, d, 16'h0000);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [15:0] e);
    wb(1'h0, idx, 16'h0000, e);
  endtask : rd

  // waits on irq_o, or on wake_o when use_wake is set
  task automatic wait_out(input logic use_wake);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((use_wake ? wake_o : irq_o) !== 1'h1 && n < 40);
    if ((use_wake ? wake_o : irq_o) !== 1'h1) timeout();
  endtask : wait_out

  // read data checker: oldest note against each read acknowledge
  always @(negedge clk_i) begin
    if (wb_ack_o === 1'h1 && req.we === 1'h0) begin
      if (exp_q.size() == 0) begin
        chk(wb_dat_o, 32'hFFFFFFFF);
      end else begin
        chk(wb_dat_o, {16'h0000, exp_q.pop_front()});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'h1;
    req = '0;
    drv_en = '1;
    drv_lvl = '0;
    src = '0;
    seed = 32'h00014793;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (rst_ix[i]) rd(rst_ix[i], 16'h0000);
    rd(16'h4701, 16'h0000);
    $display("test reset done");
    // output enables through set and clear registers
    rnd(a);
    rnd(b);
    wr(`GPDPW_IX_OESETL, a);
    @(negedge clk_i);
    chk({15'h0000, oe_o}, {16'h0000, a});
    wr(`GPDPW_IX_OESETL, 16'h0000);
    rd(`GPDPW_IX_OESETL, 16'h0000);
    rd(`GPDPW_IX_OEL, a);
    wr(`GPDPW_IX_OECLRL, b);
    rd(`GPDPW_IX_OEL, a & ~b);
    wr(`GPDPW_IX_OESETH, 16'hFFFF);
    wr(`GPDPW_IX_OECLRH, 16'hFFFE);
    rd(`GPDPW_IX_OEH, 16'h0001);
    wr(`GPDPW_IX_OECLRH, 16'h0001);
    rd(`GPDPW_IX_OECLRH, 16'h0000);
    @(negedge clk_i);
    chk({15'h0000, oe_o}, {16'h0000, a & ~b});
    $display("test output enable done");
    // pull enables
    for (int i = 0; i < 4; i++) begin
      rnd(pv[i]);
      wr(pull_ix[i], pv[i]);
      rd(pull_ix[i], pv[i] & pull_mk[i]);
    end
    @(negedge clk_i);
    chk({15'h0000, pd_o}, {15'h0000, pv[1][0], pv[0]});
    chk({15'h0000, pu_o}, {15'h0000, pv[3][0], pv[2]});
    $display("test pulls done");
    // wake: only a watched pin may wake
    rnd(a);
    wr(`GPDPW_IX_WAKEL, a);
    rd(`GPDPW_IX_WAKEL, a);
    wr(`GPDPW_IX_WAKEL, 16'h0020);
    @(posedge clk_i);
    drv_lvl <= 17'h00080;
    repeat (10) @(posedge clk_i);
    chk({31'h00000000, wake_o}, 32'h00000000);
    drv_lvl <= 17'h000A0;
    wait_out(1'h1);
    rd(`GPDPW_IX_WSTAT, 16'h0020);
    wr(`GPDPW_IX_WSTAT, 16'h0020);
    @(negedge clk_i);
    chk({31'h00000000, wake_o}, 32'h00000000);
    $display("test wake done");
    // every trigger mode, plus reserved mode 6, which must not trigger
    wr(`GPDPW_IX_IEN, 16'hFFFF);
    rd(`GPDPW_IX_IEN, 16'h000F);
    for (int m = 0; m < 7; m++) begin
      ch = m % 4;
      idle = (m == 2 || m == 5);
      hit = (m >= 1 && m <= 5);
      lvl = (m >= 4);
      bitv = 16'h0001 << ch;
      @(posedge clk_i);
      src <= idle ? bitv[3:0] : 4'h0;
      repeat (10) @(posedge clk_i);
      rnd(a);
      cfgw = {a[15:9], 1'(m & 1), 3'(m), a[4:0]};
      wr(cfg_ix[ch], cfgw);
      rd(cfg_ix[ch], cfgw & 16'h01E0);
      wr(`GPDPW_IX_IEN, bitv);
      wr(`GPDPW_IX_FLAG, 16'h000F);
      @(posedge clk_i);
      src <= idle ? 4'h0 : bitv[3:0];
      if (hit) wait_out(1'h0);
      else repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      chk({28'h0000000, chan_req_o}, hit ? {16'h0000, bitv} : 32'h00000000);
      wr(`GPDPW_IX_FLAG, bitv);
      rd(`GPDPW_IX_FLAG, (hit && lvl) ? bitv : 16'h0000);
      @(posedge clk_i);
      src <= idle ? bitv[3:0] : 4'h0;
      repeat (10) @(posedge clk_i);
      rd(`GPDPW_IX_FLAG, ((hit && lvl) || m == 3) ? bitv : 16'h0000);
      wr(cfg_ix[ch], 16'h0000);
      wr(`GPDPW_IX_FLAG, bitv);
      rd(`GPDPW_IX_FLAG, 16'h0000);
    end
    $display("test trigger modes done");
    // masked channel keeps its flag but raises no request
    wr(`GPDPW_IX_IEN, 16'h0000);
    wr(`GPDPW_IX_CFGC, 16'h0020);
    @(posedge clk_i);
    src <= 4'h4;
    repeat (10) @(posedge clk_i);
    chk({31'h00000000, irq_o}, 32'h00000000);
    rd(`GPDPW_IX_FLAG, 16'h0004);
    wr(`GPDPW_IX_IEN, 16'h0004);
    @(negedge clk_i);
    chk({31'h00000000, irq_o}, 32'h00000001);
    wr(`GPDPW_IX_FLAG, 16'h0004);
    @(negedge clk_i);
    chk({31'h00000000, irq_o}, 32'h00000000);
    $display("test mask done");
    tally_and_finish();
  end
endmodule : testbench
